// [rtl/tpc_regs.svh]
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Register indices within one port; byte address is four times the index
`define TPC_IDX_LOOP_CODE 9'h186
`define TPC_IDX_WATERMARK 9'h187
`define TPC_IDX_INTERLEAVE 9'h188
`define TPC_IDX_MON_SELECT 9'h189
`define TPC_IDX_TEST_PORT 9'h18a
`define TPC_IDX_SUPPRESS 9'h18b
`define TPC_IDX_MON_DATA 9'h18c
`define TPC_IDX_SYNC_CTRL 9'h18e
`define TPC_IDX_FIFO_STATUS 9'h191
// Index stride between ports is 0x200, so the port sits in index bits 10:9
`define TPC_PORT_LSB 9

// Writable bits per register
`define TPC_MASK_LOOP_CODE 8'h03
`define TPC_MASK_WATERMARK 8'h03
`define TPC_MASK_INTERLEAVE 8'h7f
`define TPC_MASK_MON_SELECT 8'h1f
`define TPC_MASK_TEST_PORT 8'h07
`define TPC_MASK_SUPPRESS 8'hff
`define TPC_MASK_SYNC_CTRL 8'h0f
`define TPC_RESET_VALUE 8'h00

// Field positions
`define TPC_IB_SIZE_LSB 5
`define TPC_IB_TYPE_BIT 4
`define TPC_IB_ENABLE_BIT 3
`define TPC_TP_DIR_BIT 2
`define TPC_TP_FRAMING_BIT 1
`define TPC_TP_ENABLE_BIT 0
`define TPC_SY_MFSEARCH_BIT 3
`define TPC_SY_ENABLE_BIT 2
`define TPC_SY_NOAUTO_BIT 1
`define TPC_SY_RESYNC_BIT 0
`define TPC_ST_BELOW_BIT 1

// Watermark levels, bytes
`define TPC_WM_SEL0 7'd4
`define TPC_WM_SEL1 7'd16
`define TPC_WM_SEL2 7'd32
`define TPC_WM_SEL3 7'd48
// Primary loop code lengths, bits
`define TPC_LC_SEL0 5'd5
`define TPC_LC_SEL1 5'd6
`define TPC_LC_SEL2 5'd7
`define TPC_LC_SEL3 5'd16
// Interleaved bus sizes, devices; zero marks the reserved code
`define TPC_IB_DEV0 4'd2
`define TPC_IB_DEV1 4'd4
`define TPC_IB_DEV2 4'd8
`define TPC_IB_DEV3 4'd0

`endif

// [rtl/tpc_pkg.sv]
package tpc_pkg;

	typedef struct packed {
		logic [6:0] fifo_level;
		logic chan_strobe;
		logic [4:0] chan_idx;
		logic [7:0] chan_data;
		logic bit_strobe;
		logic [2:0] bit_pos;
		logic fbit_slot;
		logic pattern_bit;
		logic tx_bit;
		logic rx_bit;
		logic e1_mode;
	} port_in_t;

	typedef struct packed {
		logic [1:0] loop_code_length;
		logic [4:0] loop_len_bits;
		logic [6:0] fifo_low_level_bytes;
		logic [3:0] shared_bus_devices;
		logic bus_size_reserved;
		logic interleave_type;
		logic interleave_enable;
		logic [3:0] slot_position;
		logic pattern_port_direction;
		logic pattern_framing_select;
		logic pattern_port_enable;
		logic [7:0] pattern_bit_suppress;
		logic synchronizer_enable;
		logic multiframe_word_search;
		logic auto_resync_enable;
	} port_cfg_t;

	typedef struct packed {
		logic tx_bit;
		logic rx_bit;
		logic pattern_take;
		logic resync_start;
		logic below_watermark_flag;
	} port_out_t;

endpackage : tpc_pkg

// [rtl/transmit_port_control_regs.sv]
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "tpc_regs.svh"

module transmit_port_control_regs
	import tpc_pkg::*;
#(
	parameter int PORTS = 4,
	parameter int ADDR_W = 16
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire port_in_t [PORTS-1:0] line_in,
	output port_cfg_t [PORTS-1:0] cfg_out,
	output port_out_t [PORTS-1:0] line_out
);

	initial begin
		if (PORTS < 1 || PORTS > 4) begin
			$error("PORTS must be 1 to 4");
		end
		if (ADDR_W < 13) begin
			$error("ADDR_W must be at least 13");
		end
	end

	// Bus decode; byte address is four times the register index
	wire logic setup = psel && !penable;
	wire logic access = psel && penable;
	wire logic [10:0] reg_index = paddr[12:2];
	wire logic [1:0] port_sel = reg_index[10:`TPC_PORT_LSB];
	wire logic [8:0] reg_sel = reg_index[8:0];
	wire logic high_zero = (ADDR_W > 13) ? (paddr >> 13) == '0 : 1'b1;
	wire logic aligned = paddr[1:0] == 2'b00;
	wire logic port_ok = {30'h0, port_sel} < PORTS;
	wire logic sel_loop = reg_sel == `TPC_IDX_LOOP_CODE;
	wire logic sel_wm = reg_sel == `TPC_IDX_WATERMARK;
	wire logic sel_ib = reg_sel == `TPC_IDX_INTERLEAVE;
	wire logic sel_msel = reg_sel == `TPC_IDX_MON_SELECT;
	wire logic sel_tp = reg_sel == `TPC_IDX_TEST_PORT;
	wire logic sel_sup = reg_sel == `TPC_IDX_SUPPRESS;
	wire logic sel_mdat = reg_sel == `TPC_IDX_MON_DATA;
	wire logic sel_sync = reg_sel == `TPC_IDX_SYNC_CTRL;
	wire logic sel_stat = reg_sel == `TPC_IDX_FIFO_STATUS;
	wire logic reg_hit = sel_loop || sel_wm || sel_ib || sel_msel || sel_tp || sel_sup ||
		sel_mdat || sel_sync || sel_stat;
	wire logic mapped = high_zero && aligned && port_ok && reg_hit;
	// Writes land only at the access edge and only on the low byte lane
	wire logic wr_go = access && pwrite && mapped && pstrb[0];
	wire logic [7:0] wbyte = pwdata[7:0];

	logic [7:0] rd_byte [PORTS];
	logic [31:0] prdata_q;
	logic pslverr_q;

	// Zero-wait access; read data and error are prepared in the setup cycle
	assign pready = access;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	wire logic [7:0] rd_sel_byte = port_ok ? rd_byte[port_sel] : 8'h00;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= (mapped && !pwrite) ? {24'h0, rd_sel_byte} : 32'h0;
			pslverr_q <= !mapped;
		end
	end

	genvar p;
	generate
		for (p = 0; p < PORTS; p++) begin : g_port
			logic [7:0] loop_q, wm_q, ib_q, msel_q, tp_q, sup_q, sync_q, mdat_q;
			logic below_prev_q, flag_q, resync_prev_q, resync_q;
			logic tx_q, rx_q;
			wire logic port_wr = wr_go && port_sel == p[1:0];
			wire logic [6:0] wm_bytes;
			wire logic below;
			wire logic flag_set;
			wire logic flag_clr;
			wire logic pattern_slot;
			wire logic inject;
			wire port_in_t li = line_in[p];

			// Masked writes keep unused bits at zero
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					loop_q <= `TPC_RESET_VALUE;
					wm_q <= `TPC_RESET_VALUE;
					ib_q <= `TPC_RESET_VALUE;
					msel_q <= `TPC_RESET_VALUE;
					tp_q <= `TPC_RESET_VALUE;
					sup_q <= `TPC_RESET_VALUE;
					sync_q <= `TPC_RESET_VALUE;
				end else if (port_wr) begin
					if (sel_loop) loop_q <= wbyte & `TPC_MASK_LOOP_CODE;
					if (sel_wm) wm_q <= wbyte & `TPC_MASK_WATERMARK;
					if (sel_ib) ib_q <= wbyte & `TPC_MASK_INTERLEAVE;
					if (sel_msel) msel_q <= wbyte & `TPC_MASK_MON_SELECT;
					if (sel_tp) tp_q <= wbyte & `TPC_MASK_TEST_PORT;
					if (sel_sup) sup_q <= wbyte & `TPC_MASK_SUPPRESS;
					if (sel_sync) sync_q <= wbyte & `TPC_MASK_SYNC_CTRL;
				end
			end

			// Loop code length, primary value; code 01 also covers 3, code 11 its divisors
			assign cfg_out[p].loop_code_length = loop_q[1:0];
			assign cfg_out[p].loop_len_bits = (loop_q[1:0] == 2'd0) ? `TPC_LC_SEL0 :
				(loop_q[1:0] == 2'd1) ? `TPC_LC_SEL1 :
				(loop_q[1:0] == 2'd2) ? `TPC_LC_SEL2 : `TPC_LC_SEL3;

			assign wm_bytes = (wm_q[1:0] == 2'd0) ? `TPC_WM_SEL0 :
				(wm_q[1:0] == 2'd1) ? `TPC_WM_SEL1 :
				(wm_q[1:0] == 2'd2) ? `TPC_WM_SEL2 : `TPC_WM_SEL3;
			assign cfg_out[p].fifo_low_level_bytes = wm_bytes;

			assign cfg_out[p].shared_bus_devices =
				(ib_q[`TPC_IB_SIZE_LSB+:2] == 2'd0) ? `TPC_IB_DEV0 :
				(ib_q[`TPC_IB_SIZE_LSB+:2] == 2'd1) ? `TPC_IB_DEV1 :
				(ib_q[`TPC_IB_SIZE_LSB+:2] == 2'd2) ? `TPC_IB_DEV2 : `TPC_IB_DEV3;
			assign cfg_out[p].bus_size_reserved = ib_q[`TPC_IB_SIZE_LSB+:2] == 2'd3;
			assign cfg_out[p].interleave_type = ib_q[`TPC_IB_TYPE_BIT];
			assign cfg_out[p].interleave_enable = ib_q[`TPC_IB_ENABLE_BIT];
			assign cfg_out[p].slot_position = {1'b0, ib_q[2:0]} + 4'd1;

			assign cfg_out[p].pattern_port_direction = tp_q[`TPC_TP_DIR_BIT];
			assign cfg_out[p].pattern_framing_select = tp_q[`TPC_TP_FRAMING_BIT];
			assign cfg_out[p].pattern_port_enable = tp_q[`TPC_TP_ENABLE_BIT];
			assign cfg_out[p].pattern_bit_suppress = sup_q;

			// Multiframe search only makes sense on E1 lines
			assign cfg_out[p].multiframe_word_search =
				sync_q[`TPC_SY_MFSEARCH_BIT] && li.e1_mode;
			assign cfg_out[p].synchronizer_enable = sync_q[`TPC_SY_ENABLE_BIT];
			assign cfg_out[p].auto_resync_enable = !sync_q[`TPC_SY_NOAUTO_BIT];

			// Channel monitor snapshot of the selected channel
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					mdat_q <= `TPC_RESET_VALUE;
				end else if (li.chan_strobe && li.chan_idx == msel_q[4:0]) begin
					mdat_q <= li.chan_data;
				end
			end

			// Pattern insertion; bit_pos 7 is the channel MSB
			assign pattern_slot = !li.fbit_slot || tp_q[`TPC_TP_FRAMING_BIT];
			assign inject = li.bit_strobe && tp_q[`TPC_TP_ENABLE_BIT] && pattern_slot &&
				!sup_q[li.bit_pos];
			assign line_out[p].pattern_take = inject;

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					tx_q <= 1'b0;
					rx_q <= 1'b0;
				end else begin
					tx_q <= (inject && !tp_q[`TPC_TP_DIR_BIT]) ? li.pattern_bit : li.tx_bit;
					rx_q <= (inject && tp_q[`TPC_TP_DIR_BIT]) ? li.pattern_bit : li.rx_bit;
				end
			end
			assign line_out[p].tx_bit = tx_q;
			assign line_out[p].rx_bit = rx_q;

			// Resync is edge triggered so a bit left high does not retrigger
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					resync_prev_q <= 1'b0;
					resync_q <= 1'b0;
				end else begin
					resync_prev_q <= sync_q[`TPC_SY_RESYNC_BIT];
					resync_q <= sync_q[`TPC_SY_RESYNC_BIT] && !resync_prev_q;
				end
			end
			assign line_out[p].resync_start = resync_q;

			// Below-watermark flag: set wins over a same-cycle clear
			assign below = li.fifo_level < wm_bytes;
			assign flag_set = below && !below_prev_q;
			assign flag_clr = port_wr && sel_stat && wbyte[`TPC_ST_BELOW_BIT];
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					below_prev_q <= 1'b0;
					flag_q <= 1'b0;
				end else begin
					below_prev_q <= below;
					flag_q <= flag_set || (flag_q && !flag_clr);
				end
			end
			assign line_out[p].below_watermark_flag = flag_q;

			always_comb begin
				rd_byte[p] = 8'h00;
				unique case (1'b1)
					sel_loop: rd_byte[p] = loop_q;
					sel_wm: rd_byte[p] = wm_q;
					sel_ib: rd_byte[p] = ib_q;
					sel_msel: rd_byte[p] = msel_q;
					sel_tp: rd_byte[p] = tp_q;
					sel_sup: rd_byte[p] = sup_q;
					sel_mdat: rd_byte[p] = mdat_q;
					sel_sync: rd_byte[p] = sync_q;
					sel_stat: rd_byte[p] = {6'h0, flag_q, 1'b0};
					default: rd_byte[p] = 8'h00;
				endcase
			end
		end
	endgenerate

endmodule : transmit_port_control_regs

// [bench/tpc_chk.sv]
`timescale 1ns/1ps
module tpc_chk
	import tpc_pkg::*;
#(parameter int PORTS = 4, parameter int ADDR_W = 16) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire port_in_t [PORTS-1:0] line_in,
	input wire port_cfg_t [PORTS-1:0] cfg_out,
	input wire port_out_t [PORTS-1:0] line_out
);
	// Port 0 only; all copies share one logic
	port_in_t i;
	port_cfg_t c;
	port_out_t o;
	logic below;
	logic below_q;
	assign i = line_in[0];
	assign c = cfg_out[0];
	assign o = line_out[0];
	assign below = i.fifo_level < c.fifo_low_level_bytes;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) below_q <= 1'b0;
		else below_q <= below;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_to_tx; o.pattern_take && !c.pattern_port_direction; endsequence
	sequence s_to_rx; o.pattern_take && c.pattern_port_direction; endsequence
	a_loop_len: assert property (c.loop_len_bits == (c.loop_code_length == 2'h0 ? 5'd5 :
		c.loop_code_length == 2'h1 ? 5'd6 : c.loop_code_length == 2'h2 ? 5'd7 : 5'd16))
		else $error("loop length decode wrong");
	a_wm_level: assert property (c.fifo_low_level_bytes inside {7'd4, 7'd16, 7'd32, 7'd48})
		else $error("watermark level illegal");
	a_bus_rsvd: assert property (c.bus_size_reserved == (c.shared_bus_devices == 4'd0))
		else $error("reserved bus size mismatch");
	a_slot_range: assert property (c.slot_position inside {[4'd1:4'd8]})
		else $error("slot position out of range");
	a_take_gate: assert property (o.pattern_take == (i.bit_strobe && c.pattern_port_enable
		&& (!i.fbit_slot || c.pattern_framing_select) && !c.pattern_bit_suppress[i.bit_pos]))
		else $error("pattern take gate wrong");
	a_tx_inject: assert property (s_to_tx |=> o.tx_bit == $past(i.pattern_bit))
		else $error("pattern missing on tx");
	a_rx_inject: assert property (s_to_rx |=> o.rx_bit == $past(i.pattern_bit))
		else $error("pattern missing on rx");
	a_mf_gate: assert property (c.multiframe_word_search |-> i.e1_mode)
		else $error("multiframe search outside E1");
	a_resync_once: assert property ($rose(o.resync_start) |=> !o.resync_start)
		else $error("resync pulse too long");
	a_flag_rise: assert property (below && !below_q |=> o.below_watermark_flag)
		else $error("below watermark flag not set");
endmodule : tpc_chk

bind transmit_port_control_regs tpc_chk #(.PORTS(PORTS), .ADDR_W(ADDR_W)) u_chk (.core_clk,
	.arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
	.line_in, .cfg_out, .line_out);

// [bench/line_feed.sv]
`timescale 1ns/1ps
module line_feed
	import tpc_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [6:0] fifo_level,
	input wire logic e1_mode,
	output port_in_t line
);
	logic [4:0] chan_q;
	logic [2:0] bit_q;
	// Free-running, as a live line keeps time
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_q <= 5'h00;
			bit_q <= 3'h0;
		end else begin
			chan_q <= chan_q + 5'h01;
			bit_q <= bit_q + 3'h1;
		end
	end
	always_comb begin
		line = '0;
		line.fifo_level = fifo_level;
		line.e1_mode = e1_mode;
		line.chan_strobe = 1'b1;
		line.chan_idx = chan_q;
		line.chan_data = {3'h5, chan_q};
		line.bit_strobe = 1'b1;
		line.bit_pos = bit_q;
		line.fbit_slot = chan_q == 5'h00;
		line.pattern_bit = chan_q[0];
		line.tx_bit = bit_q[0];
		line.rx_bit = ~bit_q[0];
	end
endmodule : line_feed

// [bench/tb_transmit_port_control_regs.sv]
`timescale 1ns/1ps
module tb_transmit_port_control_regs
	import tpc_pkg::*;
;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er;
	logic [6:0] fifo = 7'd64;
	logic e1 = 1'b0;
	port_in_t [3:0] line_in;
	port_cfg_t [3:0] cfg_out;
	port_out_t [3:0] line_out;
	int errors = 0;
	int check_count = 0;
	int lc[4] = '{5, 6, 7, 16};
	int wm[4] = '{4, 16, 32, 48};
	int dv[4] = '{2, 4, 8, 0};
	logic [8:0] idx[7] = '{9'h186, 9'h187, 9'h188, 9'h189, 9'h18a, 9'h18b, 9'h18e};
	logic [7:0] msk[7] = '{8'h03, 8'h03, 8'h7f, 8'h1f, 8'h07, 8'hff, 8'h0f};
	initial forever #5 core_clk = ~core_clk;
	transmit_port_control_regs dut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .line_in, .cfg_out, .line_out);
	for (genvar g = 0; g < 4; g++) begin : g_line
		line_feed u_feed (.core_clk, .arst_n, .fifo_level(fifo), .e1_mode(e1), .line(line_in[g]));
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input int p, input logic [8:0] ix, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= 16'((ix + 512 * p) * 4);
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic rchk(input int p, input logic [8:0] ix, input logic [7:0] e);
		apb(1'b0, p, ix, 8'h00);
		chk(rd, {24'h0, e});
	endtask : rchk
	task automatic t_regs();
		foreach (idx[k]) for (int p = 0; p < 4; p++) rchk(p, idx[k], 8'h00);
		chk(cfg_out[0].slot_position, 1);
		foreach (idx[k]) for (int p = 0; p < 4; p++) apb(1'b1, p, idx[k], 8'hff);
		foreach (idx[k]) for (int p = 0; p < 4; p++) rchk(p, idx[k], msk[k]);
		foreach (idx[k]) for (int p = 0; p < 4; p++) apb(1'b1, p, idx[k], 8'h00);
		// Low byte lane off: the write must not land
		pstrb <= 4'he;
		apb(1'b1, 0, 9'h187, 8'hff);
		chk(er, 0);
		pstrb <= 4'hf;
		rchk(0, 9'h187, 8'h00);
		apb(1'b0, 0, 9'h190, 8'h00);
		chk(er, 1);
		chk(rd, 0);
		$display("regs done");
	endtask : t_regs
	task automatic t_decode();
		logic [1:0] cc;
		for (int c = 0; c < 4; c++) begin
			cc = 2'(c);
			apb(1'b1, 0, 9'h186, {6'h0, cc});
			apb(1'b1, 0, 9'h187, {6'h0, cc});
			apb(1'b1, 0, 9'h188, {1'b0, cc, cc[0], cc[1], 3'(2 * c + 1)});
			chk(cfg_out[0].loop_len_bits, lc[c]);
			chk(cfg_out[0].fifo_low_level_bytes, wm[c]);
			chk(cfg_out[0].shared_bus_devices, dv[c]);
			chk(cfg_out[0].interleave_type, cc[0]);
			chk(cfg_out[0].interleave_enable, cc[1]);
			chk(cfg_out[0].slot_position, 2 * c + 2);
		end
		$display("decode done");
	endtask : t_decode
	task automatic t_pattern();
		apb(1'b1, 0, 9'h18b, 8'h0f);
		apb(1'b1, 0, 9'h18a, 8'h03);
		repeat (40) @(posedge core_clk);
		chk(cfg_out[0].pattern_port_enable, 1);
		chk(cfg_out[0].pattern_framing_select, 1);
		apb(1'b1, 0, 9'h18a, 8'h05);
		repeat (40) @(posedge core_clk);
		chk(cfg_out[0].pattern_port_direction, 1);
		chk(cfg_out[0].pattern_bit_suppress, 8'h0f);
		apb(1'b1, 0, 9'h18a, 8'h00);
		$display("pattern done");
	endtask : t_pattern
	task automatic t_monitor();
		apb(1'b1, 0, 9'h189, 8'h1f);
		repeat (40) @(posedge core_clk);
		rchk(0, 9'h18c, 8'hbf);
		apb(1'b1, 0, 9'h189, 8'h00);
		repeat (40) @(posedge core_clk);
		rchk(0, 9'h18c, 8'ha0);
		$display("monitor done");
	endtask : t_monitor
	task automatic t_sync();
		apb(1'b1, 0, 9'h18e, 8'h05);
		#1 chk(line_out[0].resync_start, 1);
		chk(cfg_out[0].synchronizer_enable, 1);
		chk(cfg_out[0].auto_resync_enable, 1);
		@(posedge core_clk);
		e1 <= 1'b1;
		apb(1'b1, 0, 9'h18e, 8'h0f);
		#1 chk(line_out[0].resync_start, 0);
		chk(cfg_out[0].multiframe_word_search, 1);
		chk(cfg_out[0].auto_resync_enable, 0);
		@(posedge core_clk);
		// Host clears then sets again to ask for a second resync
		apb(1'b1, 0, 9'h18e, 8'h00);
		apb(1'b1, 0, 9'h18e, 8'h01);
		#1 chk(line_out[0].resync_start, 1);
		chk(cfg_out[0].synchronizer_enable, 0);
		@(posedge core_clk);
		$display("sync done");
	endtask : t_sync
	task automatic t_flag();
		rchk(0, 9'h191, 8'h00);
		fifo <= 7'd10;
		repeat (2) @(posedge core_clk);
		rchk(0, 9'h191, 8'h02);
		apb(1'b1, 0, 9'h191, 8'h02);
		rchk(0, 9'h191, 8'h00);
		$display("flag done");
	endtask : t_flag
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		#200000;
		errors++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_decode();
		t_pattern();
		t_monitor();
		t_sync();
		t_flag();
		finish_test();
	end
endmodule : tb_transmit_port_control_regs
